// ---- logic/ssq_device.sv ----
// Device end: start-up sequencer and quadrature clock calibration.
`timescale 1ns/1ps
`include "ssq_map.svh"
// How it works
// (R01) Hold power down on low supply or pin
// (R02) Host holds reset pin high 100 us
// (R03) Reset phase 512 stable-clock cycles after power down
// (R04) Reset phase loads register reset values
// (R05) Initialising phase follows, lasting 128 cycles
// (R06) Initialising copies nonvolatile bytes into 10h-2Fh
// (R07) Command reads 3Fh throughout start-up
// (R08) Idle command entered after initialising, reads 00h
// (R09) Host polls command until 00h
// (R10) Page write of 80h detects host interface
// (R11) Command read 00h confirms interface ready
// (R12) Page write 00h selects linear addressing
// (R13) One calibration runs after reset phase always
// (R14) Hold clear: calibrate after each transceive
// (R15) Hold set: suppress automatic calibrations
// (R16) Hold rising edge starts one calibration
// (R17) Calibration finishes within 65 cycles
// (R18) Delay readable; flag shift over half turn
// (R19) Delay writes need hold set 4.8 us
// (R20) Hold clear: next calibration overwrites delay
// (R21) Power down restarts sequence from any phase
// (R22) Reset count waits for oscillator stable
module ssq_device #(
   parameter int RESET_CYC = `SSQ_RESET_CYC,
   parameter int INIT_CYC = `SSQ_INIT_CYC,
   parameter int CAL_CYC = `SSQ_CAL_CYC
) (
   input wire logic clk_in, // Oscillator clock.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic digital_supply_ok_in, // Digital supply above threshold.
   input wire logic analog_supply_ok_in, // Analog supply above threshold.
   input wire logic osc_stable_in, // Oscillator running stably.
   input wire logic txrx_done_in, // Transceive command finished.
   input wire logic [5:0] phase_meas_in, // Measured Q/I phase, msb over half.
   output logic [4:0] nv_addr_out, // Nonvolatile byte address.
   input wire logic [7:0] nv_data_in, // Nonvolatile byte, cycle after address.
   output logic [5:0] cmd_out, // Current command field.
   output logic cal_busy_out, // Calibration running.
   output logic [4:0] quadrature_delay_value_out, // Delay in use.
   output logic phase_over_half_flag_out, // Phase shift above 180 degrees.
   ssq_if.dev bus // Host link.
);
   typedef struct packed {
      ssq_pkg::ssq_dev_st_t st;
      logic [9:0] cnt;
      logic [5:0] cmd;
      logic [7:0] page;
      logic iface_ok;
      logic linear;
      logic calibration_hold_bit;
      logic [4:0] dly;
      logic over_half;
      logic cal_busy;
      logic [6:0] cal_cnt;
      logic [7:0] rdata;
      logic [31:0][7:0] cfg;
   } ssq_dev_s_t;
   ssq_dev_s_t q, d;
   logic hpd;
   logic [5:0] ea;

   // ----------------------------------------
   // Helpers.
   // ----------------------------------------
   // Paged mode forms the address from the page and the low pin bits.
   function automatic logic [5:0] eff_addr(input logic lin,
      input logic [7:0] pg, input logic [5:0] a);
      eff_addr = lin ? a : {pg[2:0], a[2:0]};
   endfunction : eff_addr

   // True for addresses inside the configuration window.
   function automatic logic is_cfg(input logic [5:0] a);
      is_cfg = (a >= `SSQ_CFG_FIRST) && (a <= `SSQ_CFG_LAST);
   endfunction : is_cfg

   // Any power down cause, level sensitive.
   assign hpd = !digital_supply_ok_in || !analog_supply_ok_in ||
      bus.power_down_reset_pin; // R01
   assign ea = eff_addr(q.linear, q.page, bus.addr);

   // ----------------------------------------
   // Next-state logic.
   // ----------------------------------------
   always_comb
   begin
      d = q;
      d.rdata = 8'h00;
      // Calibration counter runs while a calibration is busy, whatever the phase.
      if (q.cal_busy)
      begin
         d.cal_cnt = q.cal_cnt + 7'h01;
         if (q.cal_cnt == 7'(CAL_CYC - 1)) // R17
         begin
            d.cal_busy = 1'b0;
            d.dly = phase_meas_in[4:0]; // R18 R20
            d.over_half = phase_meas_in[5]; // R18
         end
      end
      // Reads answer in the next cycle only.
      if (bus.rd)
      begin
         if (ea == `SSQ_REG_CMD)
            d.rdata = {2'h0, q.cmd}; // R07 R11
         else if (ea == `SSQ_REG_PAGE)
            d.rdata = q.page;
         else if (ea == `SSQ_REG_CALCTL)
            d.rdata = {7'h00, q.calibration_hold_bit};
         else if (ea == `SSQ_REG_DELAY)
            d.rdata = {2'h0, q.over_half, q.dly}; // R18
         else if (is_cfg(ea))
            d.rdata = q.cfg[5'(ea - `SSQ_CFG_FIRST)];
      end
      unique case (q.st)
         ssq_pkg::DS_HPD:
         begin
            d.cnt = 10'h000;
            d.cmd = `SSQ_CMD_STARTUP;
            d.cal_busy = 1'b0;
            if (!hpd)
               d.st = ssq_pkg::DS_RESET; // R03
         end
         ssq_pkg::DS_RESET:
         begin
            d.cmd = `SSQ_CMD_STARTUP; // R04 R07
            d.page = 8'h00; // R04
            d.iface_ok = 1'b0;
            d.linear = 1'b0;
            d.calibration_hold_bit = 1'b0;
            d.dly = 5'h00;
            d.over_half = 1'b0;
            d.cfg = '0;
            if (osc_stable_in) // R22
            begin
               d.cnt = q.cnt + 10'h001;
               if (q.cnt == 10'(RESET_CYC - 1)) // R03
               begin
                  d.cnt = 10'h000;
                  d.st = ssq_pkg::DS_INIT; // R05
                  d.cal_busy = 1'b1; // R13
                  d.cal_cnt = 7'h00;
               end
            end
         end
         ssq_pkg::DS_INIT:
         begin
            d.cnt = q.cnt + 10'h001;
            // Byte addressed in cycle n arrives in cycle n+1.
            if (q.cnt != 10'h000 && q.cnt <= 10'(`SSQ_NV_BYTES))
               d.cfg[5'(q.cnt - 10'h001)] = nv_data_in; // R06
            if (q.cnt == 10'(INIT_CYC - 1)) // R05
            begin
               d.st = ssq_pkg::DS_RUN;
               d.cmd = `SSQ_CMD_IDLE; // R08
            end
         end
         ssq_pkg::DS_RUN:
         begin
            if (bus.wr && ea == `SSQ_REG_PAGE)
            begin
               d.page = bus.wdata;
               if (!q.iface_ok && bus.wdata == `SSQ_PAGE_DETECT)
                  d.iface_ok = 1'b1; // R10
               else if (q.iface_ok && bus.wdata == `SSQ_PAGE_LINEAR)
                  d.linear = 1'b1; // R12
            end
            else if (bus.wr && ea == `SSQ_REG_CMD && q.iface_ok)
               d.cmd = bus.wdata[5:0];
            else if (bus.wr && ea == `SSQ_REG_CALCTL && q.iface_ok)
            begin
               d.calibration_hold_bit = bus.wdata[0];
               if (bus.wdata[0] && !q.calibration_hold_bit)
               begin
                  d.cal_busy = 1'b1; // R16
                  d.cal_cnt = 7'h00;
               end
            end
            else if (bus.wr && ea == `SSQ_REG_DELAY && q.iface_ok &&
               !q.cal_busy)
               d.dly = bus.wdata[4:0]; // R19
            else if (bus.wr && is_cfg(ea) && q.iface_ok)
               d.cfg[5'(ea - `SSQ_CFG_FIRST)] = bus.wdata;
            // End of transceive returns to idle and may recalibrate.
            if (txrx_done_in && q.cmd == `SSQ_CMD_TRANSCEIVE)
            begin
               d.cmd = `SSQ_CMD_IDLE;
               if (!q.calibration_hold_bit) // R14 R15
               begin
                  d.cal_busy = 1'b1; // R20
                  d.cal_cnt = 7'h00;
               end
            end
         end
      endcase
      if (hpd)
         d.st = ssq_pkg::DS_HPD; // R21
   end

   // ----------------------------------------
   // State register.
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         q <= '0;
         q.cmd <= `SSQ_CMD_STARTUP;
      end
      else
         q <= d;
   end

   // Outputs come from the state.
   assign nv_addr_out = q.cnt[4:0];
   assign cmd_out = q.cmd;
   assign cal_busy_out = q.cal_busy;
   assign quadrature_delay_value_out = q.dly;
   assign phase_over_half_flag_out = q.over_half;
   assign bus.rdata = q.rdata;
endmodule : ssq_device

// ---- logic/ssq_host.sv ----
// Host end: runs interface detection and bridges software accesses.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "ssq_map.svh"
module ssq_host #(
   parameter int PD_MIN_CYC = `SSQ_PD_MIN_CYC,
   parameter int HOLD_WAIT_CYC = `SSQ_HOLD_WAIT_CYC
) (
   input wire logic clk_in, // System clock.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic [3:0] addr_in, // Register address.
   input wire logic [7:0] wdata_in, // Write data.
   input wire logic wr_in, // Write strobe.
   input wire logic rd_in, // Read strobe.
   output logic [7:0] rdata_out, // Read data, cycle after strobe.
   ssq_if.host bus // Device link.
);
   typedef struct packed {
      ssq_pkg::ssq_host_st_t st;
      logic [15:0] pd_cnt;
      logic [10:0] hold_cnt;
      logic hold_on;
      logic busy;
      logic done;
      logic fail;
      logic refused;
      logic [5:0] daddr;
      logic [7:0] dwdata;
      logic dwrite;
      logic [7:0] drdata;
      logic [5:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic pin;
      logic [7:0] rdata;
   } ssq_host_s_t;
   ssq_host_s_t q, d;

   // ----------------------------------------
   // Next-state logic.
   // ----------------------------------------
   always_comb
   begin
      d = q;
      d.wr = 1'b0;
      d.rd = 1'b0;
      d.rdata = 8'h00;
      if (q.hold_on && q.hold_cnt != HOLD_WAIT_CYC[10:0])
         d.hold_cnt = q.hold_cnt + 11'h001; // R19
      if (rd_in)
      begin
         unique case (addr_in)
            `SSQ_H_STATUS: d.rdata = {4'h0, q.refused, q.fail, q.done, q.busy};
            `SSQ_H_DADDR: d.rdata = {2'h0, q.daddr};
            `SSQ_H_DWDATA: d.rdata = q.dwdata;
            `SSQ_H_DRDATA: d.rdata = q.drdata;
            default: d.rdata = 8'h00;
         endcase
      end
      if (wr_in && addr_in == `SSQ_H_DADDR)
         d.daddr = wdata_in[5:0];
      if (wr_in && addr_in == `SSQ_H_DWDATA)
         d.dwdata = wdata_in;
      unique case (q.st)
         ssq_pkg::HS_IDLE:
         begin
            d.busy = 1'b0;
            if (wr_in && addr_in == `SSQ_H_CTRL && wdata_in[`SSQ_CTRL_PD])
            begin
               d.st = ssq_pkg::HS_PD;
               d.pin = 1'b1;
               d.pd_cnt = 16'h0000;
               d.busy = 1'b1;
               d.done = 1'b0;
            end
            else if (wr_in && addr_in == `SSQ_H_CTRL &&
               wdata_in[`SSQ_CTRL_INIT])
            begin
               d.st = ssq_pkg::HS_POLL;
               d.busy = 1'b1;
               d.done = 1'b0;
               d.fail = 1'b0;
            end
            else if (wr_in && addr_in == `SSQ_H_DCMD)
            begin
               d.dwrite = wdata_in[`SSQ_DCMD_WRITE];
               d.refused = 1'b0;
               d.busy = 1'b1;
               d.st = ssq_pkg::HS_ACC;
            end
         end
         // Reset pulse held for the least documented width.
         ssq_pkg::HS_PD:
         begin
            d.pd_cnt = q.pd_cnt + 16'h0001;
            if (q.pd_cnt == PD_MIN_CYC[15:0] - 16'h0001) // R02
            begin
               d.pin = 1'b0;
               d.st = ssq_pkg::HS_IDLE;
            end
         end
         ssq_pkg::HS_POLL:
         begin
            d.rd = 1'b1;
            d.addr = `SSQ_REG_CMD;
            d.st = ssq_pkg::HS_POLL_W;
         end
         ssq_pkg::HS_POLL_W: d.st = ssq_pkg::HS_POLL_C;
         ssq_pkg::HS_POLL_C:
            d.st = (bus.rdata[5:0] == `SSQ_CMD_IDLE) ?
               ssq_pkg::HS_PAGE : ssq_pkg::HS_POLL; // R09
         ssq_pkg::HS_PAGE:
         begin
            d.wr = 1'b1; // R10
            d.addr = `SSQ_REG_PAGE;
            d.wdata = `SSQ_PAGE_DETECT;
            d.st = ssq_pkg::HS_CHK;
         end
         ssq_pkg::HS_CHK:
         begin
            d.rd = 1'b1;
            d.addr = `SSQ_REG_CMD;
            d.st = ssq_pkg::HS_CHK_W;
         end
         ssq_pkg::HS_CHK_W: d.st = ssq_pkg::HS_CHK_C;
         ssq_pkg::HS_CHK_C:
         begin
            if (bus.rdata == 8'h00) // R11
               d.st = ssq_pkg::HS_LIN;
            else
            begin
               d.fail = 1'b1;
               d.st = ssq_pkg::HS_IDLE;
            end
         end
         ssq_pkg::HS_LIN:
         begin
            d.wr = 1'b1; // R12
            d.addr = `SSQ_REG_PAGE;
            d.wdata = `SSQ_PAGE_LINEAR;
            d.done = 1'b1;
            d.st = ssq_pkg::HS_IDLE;
         end
         ssq_pkg::HS_ACC:
         begin
            d.addr = q.daddr;
            d.wdata = q.dwdata;
            if (!q.dwrite)
            begin
               d.rd = 1'b1;
               d.st = ssq_pkg::HS_ACC_W;
            end
            else if (q.daddr == `SSQ_REG_DELAY &&
               !(q.hold_on && q.hold_cnt == HOLD_WAIT_CYC[10:0]))
            begin
               d.refused = 1'b1; // R19
               d.st = ssq_pkg::HS_IDLE;
            end
            else
            begin
               d.wr = 1'b1;
               if (q.daddr == `SSQ_REG_CALCTL)
               begin
                  d.hold_on = q.dwdata[0]; // R19
                  if (!q.hold_on)
                     d.hold_cnt = 11'h000;
               end
               d.st = ssq_pkg::HS_IDLE;
            end
         end
         ssq_pkg::HS_ACC_W: d.st = ssq_pkg::HS_ACC_C;
         ssq_pkg::HS_ACC_C:
         begin
            d.drdata = bus.rdata;
            d.st = ssq_pkg::HS_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State register.
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         q <= '0;
      else
         q <= d;
   end

   // Link and software outputs come straight from the state.
   assign bus.addr = q.addr;
   assign bus.wdata = q.wdata;
   assign bus.wr = q.wr;
   assign bus.rd = q.rd;
   assign bus.power_down_reset_pin = q.pin;
   assign rdata_out = q.rdata;
endmodule : ssq_host

// ---- logic/ssq_if.sv ----
// Parallel register link between host and reader device.
`timescale 1ns/1ps
interface ssq_if;
   logic [5:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic power_down_reset_pin;
   modport dev (input addr, wdata, wr, rd, power_down_reset_pin,
      output rdata);
   modport host (output addr, wdata, wr, rd, power_down_reset_pin,
      input rdata);
endinterface : ssq_if

// ---- logic/ssq_map.svh ----
// Offsets, field positions, reset values and timing counts of the sequencer.
`ifndef SSQ_MAP_SVH
`define SSQ_MAP_SVH
`define SSQ_REG_PAGE 6'h00
`define SSQ_REG_CMD 6'h01
`define SSQ_REG_CALCTL 6'h08
`define SSQ_REG_DELAY 6'h09
`define SSQ_CFG_FIRST 6'h10
`define SSQ_CFG_LAST 6'h2F
`define SSQ_CMD_STARTUP 6'h3F
`define SSQ_CMD_IDLE 6'h00
`define SSQ_CMD_TRANSCEIVE 6'h1E
`define SSQ_PAGE_DETECT 8'h80
`define SSQ_PAGE_LINEAR 8'h00
`define SSQ_RESET_CYC 512
`define SSQ_INIT_CYC 128
`define SSQ_CAL_CYC 65
`define SSQ_NV_BYTES 32
`define SSQ_CLK_MHZ 250
`define SSQ_PD_MIN_US 100
`define SSQ_PD_MIN_CYC (`SSQ_PD_MIN_US * `SSQ_CLK_MHZ)
`define SSQ_HOLD_WAIT_NS 4800
`define SSQ_HOLD_WAIT_CYC ((`SSQ_HOLD_WAIT_NS * `SSQ_CLK_MHZ + 999) / 1000)
`define SSQ_H_CTRL 4'h0
`define SSQ_H_STATUS 4'h1
`define SSQ_H_DADDR 4'h2
`define SSQ_H_DWDATA 4'h3
`define SSQ_H_DCMD 4'h4
`define SSQ_H_DRDATA 4'h5
`define SSQ_CTRL_INIT 0
`define SSQ_CTRL_PD 1
`define SSQ_DCMD_WRITE 0
`endif

// ---- logic/ssq_pkg.sv ----
// Types shared by both ends of the start-up sequencer.
package ssq_pkg;
   typedef enum logic [1:0] {DS_HPD, DS_RESET, DS_INIT, DS_RUN} ssq_dev_st_t;
   typedef enum logic [3:0] {
      HS_IDLE, HS_PD, HS_POLL, HS_POLL_W, HS_POLL_C, HS_PAGE, HS_CHK,
      HS_CHK_W, HS_CHK_C, HS_LIN, HS_ACC, HS_ACC_W, HS_ACC_C
   } ssq_host_st_t;
endpackage : ssq_pkg

// ---- tb/ssq_chk.sv ----
// Checker for the link between the host end and the device end.
`timescale 1ns/1ps
module ssq_chk #(
   parameter int RESET_CYC = 512,
   parameter int INIT_CYC = 128,
   parameter int PD_MIN_CYC = 25000,
   parameter int HOLD_WAIT_CYC = 1200
) (
   input wire logic clk_in, // Clock.
   input wire logic resetn_in, // Reset, active low.
   input wire logic [5:0] addr, // Link address.
   input wire logic [7:0] wdata, // Link write data.
   input wire logic wr, // Write strobe.
   input wire logic rd, // Read strobe.
   input wire logic [7:0] rdata, // Link read data.
   input wire logic power_down_reset_pin // Power down request.
);
   // --------
   // Helper state
   // --------
   int pd_len_q, since_q, hold_cnt_q;
   logic rd_cmd_q, idle_q, det_q, lin_q, hold_q, cmdw_q;
   logic pg80, pg00;
   // Page writes that start detection and linear addressing.
   assign pg80 = wr && addr == 6'h00 && wdata == 8'h80;
   assign pg00 = wr && addr == 6'h00 && wdata == 8'h00;
   // Tracks pulse width, start-up age and handshake progress.
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         pd_len_q <= 0;
         since_q <= 0;
         hold_cnt_q <= 0;
         {rd_cmd_q, idle_q, det_q, lin_q, hold_q, cmdw_q} <= 6'h00;
      end
      else
      begin
         pd_len_q <= power_down_reset_pin ? pd_len_q + 1 : 0;
         since_q <= power_down_reset_pin ? 0 : since_q + 1;
         hold_cnt_q <= (wr && addr == 6'h08) ? 0 : hold_cnt_q + 1;
         rd_cmd_q <= rd && addr == 6'h01;
         if (rd_cmd_q)
            idle_q <= rdata == 8'h00;
         if (power_down_reset_pin)
            {det_q, lin_q, hold_q, cmdw_q} <= 4'h0;
         else
         begin
            det_q <= det_q | pg80;
            lin_q <= lin_q | (pg00 && det_q);
            cmdw_q <= cmdw_q | (wr && addr == 6'h01);
            if (wr && lin_q && addr == 6'h08)
               hold_q <= wdata[0];
         end
      end
   end
   // --------
   // Properties
   // --------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   start_cmd_a: assert property (
      rd && addr == 6'h01 && since_q < RESET_CYC + INIT_CYC
      |=> rdata == 8'h3F) else $error("command not 3F in start-up");
   pd_width_a: assert property (
      $fell(power_down_reset_pin) |-> pd_len_q >= PD_MIN_CYC)
      else $error("power down pulse too short");
   idle_first_a: assert property (
      pg80 |-> idle_q) else $error("page write before idle seen");
   detect_read_a: assert property (
      pg80 |-> ##[1:12] (rd && addr == 6'h01))
      else $error("no command read after detection");
   detect_ok_a: assert property (
      rd && addr == 6'h01 && det_q && !cmdw_q |=> rdata == 8'h00)
      else $error("command not idle after detection");
   linear_mode_a: assert property (
      pg00 && !lin_q |-> det_q) else $error("linear before detection");
   hold_wait_a: assert property (
      wr && lin_q && addr == 6'h09
      |-> hold_q && hold_cnt_q >= HOLD_WAIT_CYC - 1)
      else $error("delay written without settled hold");
   quiet_rdata_a: assert property (
      !$past(rd) |-> rdata == 8'h00) else $error("read data not idle");
   cover property (pg80);
   cover property ($fell(power_down_reset_pin));
   cover property (wr && lin_q && addr == 6'h09);
   cover property (rd_cmd_q && rdata == 8'h3F);
endmodule : ssq_chk

// ---- tb/startup_sequencer_qclock_calibration_tb.sv ----
// Self-checking bench for the start-up sequencer with both link ends.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
   fail_count++; \
   $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module startup_sequencer_qclock_calibration_tb;
   // --------
   // Bench
   // --------
   localparam int RST = 64;
   localparam int INI = 40;
   localparam int CAL = 65;
   localparam int HOLD = 30;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [3:0] addr_q = 4'h0;
   logic [7:0] wdata_q = 8'h00;
   logic wr_q = 1'b0;
   logic rd_q = 1'b0;
   logic dsup_q = 1'b1;
   logic asup_q = 1'b1;
   logic osc_q = 1'b0;
   logic txrx_q = 1'b0;
   logic [5:0] phase_q = 6'h00;
   logic [7:0] nv_q = 8'h00;
   logic [7:0] rdata, r, s;
   logic [4:0] nv_addr, dly, v;
   logic [5:0] cmd, ph;
   logic busy, flag;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int seed = 71805;
   int n, m, c;
   int nv_mem[$];
   ssq_if bus ();
   ssq_host #(.PD_MIN_CYC(20), .HOLD_WAIT_CYC(HOLD)) i_ssq_host (
      .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_q),
      .wdata_in(wdata_q), .wr_in(wr_q), .rd_in(rd_q), .rdata_out(rdata),
      .bus(bus));
   ssq_device #(.RESET_CYC(RST), .INIT_CYC(INI), .CAL_CYC(CAL))
      i_ssq_device (
      .clk_in(clk_in), .resetn_in(resetn_in), .digital_supply_ok_in(dsup_q),
      .analog_supply_ok_in(asup_q), .osc_stable_in(osc_q),
      .txrx_done_in(txrx_q), .phase_meas_in(phase_q), .nv_addr_out(nv_addr),
      .nv_data_in(nv_q), .cmd_out(cmd), .cal_busy_out(busy),
      .quadrature_delay_value_out(dly), .phase_over_half_flag_out(flag),
      .bus(bus));
   ssq_chk #(.RESET_CYC(RST), .INIT_CYC(INI), .PD_MIN_CYC(20),
      .HOLD_WAIT_CYC(HOLD)) i_ssq_chk (
      .clk_in(clk_in), .resetn_in(resetn_in), .addr(bus.addr),
      .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
      .power_down_reset_pin(bus.power_down_reset_pin));
   // Clock, nonvolatile store model and run ceiling.
   always #2 clk_in = ~clk_in;
   always @(posedge clk_in)
   begin
      nv_q <= 8'(nv_mem[nv_addr]);
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop
   // Waits until just after the next rising edge.
   task automatic tick();
      @(posedge clk_in);
      #1;
   endtask : tick
   // Software port write and read cycles.
   task automatic hw(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_q <= a;
      wdata_q <= d;
      wr_q <= 1'b1;
      @(posedge clk_in);
      wr_q <= 1'b0;
   endtask : hw
   task automatic hr(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_q <= a;
      rd_q <= 1'b1;
      @(posedge clk_in);
      rd_q <= 1'b0;
      #1;
      d = rdata;
   endtask : hr
   // Polls the status word until the host is no longer busy.
   task automatic wait_idle();
      int k;
      k = 0;
      hr(4'h1, s);
      while (s[0] !== 1'b0 && k < 3000)
      begin
         hr(4'h1, s);
         k++;
      end
      // A host that never goes idle counts as a mismatch.
      if (k == 3000)
         fail_count++;
   endtask : wait_idle
   // One device access through the host bridge registers.
   task automatic dev(input logic [5:0] a, input logic [7:0] d,
      input logic w);
      hw(4'h2, {2'b00, a});
      hw(4'h3, d);
      hw(4'h4, {7'h00, w});
      wait_idle();
      hr(4'h5, r);
   endtask : dev
   // Pulses the transceive end and sets the measured phase.
   task automatic drive(input logic t, input logic [5:0] p);
      @(posedge clk_in);
      txrx_q <= t;
      phase_q <= p;
      @(posedge clk_in);
      txrx_q <= 1'b0;
      #1;
   endtask : drive
   // Expects a calibration or none, then after a calibration the delay result.
   task automatic cal_check(input logic e);
      int k;
      k = 0;
      while (busy !== 1'b1 && k < 12)
      begin
         tick();
         k++;
      end
      `CHK(busy, e)
      while (busy === 1'b1 && k < 120)
      begin
         tick();
         k++;
      end
      if (e)
      begin
         `CHK(dly, ph[4:0])
         `CHK(flag, ph[5])
      end
   endtask : cal_check
   // Main sequence.
   initial
   begin
      for (n = 0; n < 32; n++)
         nv_mem.push_back($random(seed) & 255);
      phase_q = 6'($random(seed));
      repeat (16) @(posedge clk_in);
      resetn_in <= 1'b1;
      hw(4'h0, 8'h01);
      repeat (40) tick();
      `CHK(cmd, 6'h3F)
      `CHK(busy, 1'b0)
      @(posedge clk_in);
      osc_q <= 1'b1;
      n = 0;
      while (busy !== 1'b1 && n < 1000)
      begin
         tick();
         n++;
      end
      `CHK(n >= RST && n <= RST + 1, 1'b1)
      m = 0;
      c = 0;
      repeat (100)
      begin
         if (busy === 1'b1)
            m++;
         if (cmd !== 6'h00)
            c++;
         tick();
      end
      `CHK(m, CAL)
      `CHK(c >= INI - 1 && c <= INI + 1, 1'b1)
      `CHK(dly, phase_q[4:0])
      `CHK(flag, phase_q[5])
      wait_idle();
      `CHK(s[2:1], 2'b01)
      `CHK(cmd, 6'h00)
      for (n = 0; n < 32; n++)
      begin
         dev(6'h10 + 6'(n), 8'h00, 1'b0);
         `CHK(r, 8'(nv_mem[n]))
      end
      dev(6'h09, 8'h00, 1'b0);
      `CHK(r[5:0], phase_q)
      ph = 6'($random(seed));
      drive(1'b0, ph);
      dev(6'h08, 8'h01, 1'b1);
      v = 5'($random(seed));
      dev(6'h09, {3'b000, v}, 1'b1);
      `CHK(s[3], 1'b1)
      cal_check(1'b1);
      dev(6'h09, {3'b000, v}, 1'b1);
      `CHK(dly, v)
      dev(6'h01, 8'h1E, 1'b1);
      ph = ~ph;
      drive(1'b1, ph);
      cal_check(1'b0);
      `CHK(dly, v)
      dev(6'h08, 8'h00, 1'b1);
      dev(6'h01, 8'h1E, 1'b1);
      drive(1'b1, ph);
      cal_check(1'b1);
      for (n = 0; n < 2; n++)
      begin
         @(posedge clk_in);
         {dsup_q, asup_q} <= (n == 1) ? 2'b01 : 2'b10;
         repeat (4) tick();
         `CHK(cmd, 6'h3F)
         @(posedge clk_in);
         {dsup_q, asup_q} <= 2'b11;
         m = 0;
         while (cmd !== 6'h00 && m < 400)
         begin
            tick();
            m++;
         end
         `CHK(m >= RST + INI, 1'b1)
      end
      hw(4'h0, 8'h02);
      repeat (6) tick();
      `CHK(cmd, 6'h3F)
      wait_idle();
      hw(4'h0, 8'h01);
      wait_idle();
      `CHK(s[2:1], 2'b01)
      `CHK(cmd, 6'h00)
      report_and_stop();
   end
endmodule : startup_sequencer_qclock_calibration_tb
